// >>> core/gstm_top.sv
// Gas sensor readout: fault supervision, compensation and threshold channels
// Functional notes
// - Treat module as warming up five minutes
// - Self-calibration only after 24h unbroken power
// - Concentration span is 0 to 2000 ppm
// - Compensate reading for pressure via site altitude
// - Altitude in whole metres above sea level
// - Pressure offset from 100 m step table
// - Poll sensor; persistent loss sets fault ON
// - Faulty module disabled, value output zero
// - Device reset restarts module, fault re-evaluated
// - Four CO2 and two humidity channels, configurable
// - Configured limit loaded at init and download
// - External value replaces limit until replaced
// - Teach copies current measured value into limit
// - Per channel hysteresis and direction response
// - Release waits for hysteresis past the limit
// - CO2 limits default 400/800/1200/1600 ppm
// - Teach acts only on received value one
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gstm_params.svh"

module gstm_chan (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Control
  input wire logic load_in,
  input wire logic act_in,
  input wire logic dir_in,
  input wire logic [15:0] cfg_lim_in,
  input wire logic [15:0] hyst_in,
  // Sources
  input wire logic ext_stb_in,
  input wire logic [15:0] ext_val_in,
  input wire logic teach_stb_in,
  input wire logic [15:0] meas_in,
  input wire logic eval_in,
  // Results
  output logic [15:0] lim_out,
  output logic state_out
);
  logic [15:0] lim_ff;
  logic state_ff;
  logic [15:0] nxt_lim;
  logic nxt_state;
  wire [16:0] meas_hi = {1'b0, meas_in} + {1'b0, hyst_in};
  wire [16:0] lim_hi = {1'b0, lim_ff} + {1'b0, hyst_in};
  // Dir 0: on above limit, off below limit-hyst; dir 1 mirrored
  wire set_c = dir_in ? (meas_in < lim_ff) : (meas_in > lim_ff);
  wire clr_c = dir_in ? ({1'b0, meas_in} > lim_hi) : (meas_hi < {1'b0, lim_ff});

  // Download wins over any runtime replacement in the same cycle
  assign nxt_lim = load_in ? cfg_lim_in :
                   ext_stb_in ? ext_val_in :
                   teach_stb_in ? meas_in : lim_ff;
  assign nxt_state = (load_in || !act_in) ? 1'b0 :
                     (eval_in && set_c) ? 1'b1 :
                     (eval_in && clr_c) ? 1'b0 : state_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lim_ff <= 16'h0000;
      state_ff <= 1'b0;
    end else begin
      lim_ff <= nxt_lim;
      state_ff <= nxt_state;
    end
  end

  assign lim_out = lim_ff;
  assign state_out = state_ff;
endmodule // gstm_chan

module gstm_top #(
  parameter int unsigned SEC_CYC = `GS_CLK_HZ,
  parameter int unsigned CAL_SEC = `GS_CAL_SEC,
  parameter int unsigned POLL_CYC = `GS_POLL_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Power and device reset
  input wire logic bus_pwr_in,
  // Sensor module
  input wire logic [15:0] co2_raw_in,
  input wire logic co2_vld_in,
  input wire logic sns_ack_in,
  input wire logic [15:0] hum_in,
  input wire logic hum_vld_in,
  output logic poll_out,
  output logic mod_en_out,
  output logic cal_en_out,
  output logic warm_done_out,
  // Limit sources from the bus
  input wire logic ext_stb_in,
  input wire logic [2:0] ext_ch_in,
  input wire logic [15:0] ext_val_in,
  input wire logic teach_stb_in,
  input wire logic [2:0] teach_ch_in,
  input wire logic teach_bit_in,
  // Results
  output logic [15:0] co2_val_out,
  output logic fault_out,
  output logic fault_tx_out,
  output logic [5:0] thr_out,
  output logic irq_out
);
  localparam int NCH = `GS_NCH;

  gstm_pkg::gstm_mod_t mod_ff, nxt_mod;
  logic [15:0] ctrl_ff, alt_ff, value_ff;
  logic [15:0] cfg_lim_ff [NCH];
  logic [15:0] hyst_ff [NCH];
  logic [2:0] irq_st_ff, irq_msk_ff;
  logic [15:0] rdata_ff;
  logic pwr_d_ff, fault_ff, fault_tx_ff, poll_ff, irq_ff, mod_en_ff;
  logic [24:0] sec_cnt_ff;
  logic [8:0] warm_sec_ff;
  logic [16:0] up_sec_ff;
  logic [15:0] poll_cnt_ff;
  logic [1:0] miss_ff;
  logic ack_seen_ff, warm_ff, cal_ff;
  logic [5:0] thr_q;
  logic [15:0] lim_q [NCH];
  logic [4:0] alt_idx;

  // Device reset: configuration download or bus power return
  wire wr_load = wr_in && (addr_in == `GS_ADDR_LOAD) && wdata_in[0];
  wire pwr_rise = bus_pwr_in && !pwr_d_ff;
  wire dev_rst = wr_load || pwr_rise;
  wire sec_tick = (sec_cnt_ff == 25'(SEC_CYC - 1));
  wire poll_tick = (poll_cnt_ff == 16'(POLL_CYC - 1));

  // Altitude step index, 1 m resolution held in alt_ff
  always_comb begin
    alt_idx = 5'h00;
    for (int i = 1; i <= 20; i++) begin
      if (alt_ff >= 16'(i * `GS_ALT_STEP)) begin
        alt_idx = 5'(i);
      end
    end
  end

  // Pressure offset in 0.1 hPa per 100 m step
  function automatic logic [11:0] dp_of(input logic [4:0] idx);
    case (idx)
      5'h01: dp_of = 12'h078;
      5'h02: dp_of = 12'h0EE;
      5'h03: dp_of = 12'h163;
      5'h04: dp_of = 12'h1D8;
      5'h05: dp_of = 12'h24B;
      5'h06: dp_of = 12'h2BD;
      5'h07: dp_of = 12'h32D;
      5'h08: dp_of = 12'h39D;
      5'h09: dp_of = 12'h40C;
      5'h0A: dp_of = 12'h479;
      5'h0B: dp_of = 12'h4E6;
      5'h0C: dp_of = 12'h551;
      5'h0D: dp_of = 12'h5BC;
      5'h0E: dp_of = 12'h625;
      5'h0F: dp_of = 12'h68D;
      5'h10: dp_of = 12'h6F5;
      5'h11: dp_of = 12'h75B;
      5'h12: dp_of = 12'h7C0;
      5'h13: dp_of = 12'h824;
      5'h14: dp_of = 12'h888;
      default: dp_of = 12'h000;
    endcase
  endfunction

  // Lower pressure at altitude deflates the raw reading, so scale it up
  wire [11:0] dp = dp_of(alt_idx);
  wire [38:0] corr_prod = 39'(co2_raw_in) * 39'(dp) * 39'(`GS_P0_RECIP);
  wire [16:0] corr_sum = {1'b0, co2_raw_in} + 17'(corr_prod >> `GS_P0_SHIFT);
  wire [15:0] co2_sat = (corr_sum > 17'(`GS_SPAN_MAX)) ? `GS_SPAN_MAX : corr_sum[15:0];
  wire running = (mod_ff == gstm_pkg::GS_RUN);
  wire co2_eval = co2_vld_in && running && warm_ff;
  wire [15:0] nxt_value = !running ? 16'h0000 :
                          co2_vld_in ? co2_sat : value_ff;

  // Module supervision: any ack proves life, repeated silent polls mean fault
  always_comb begin
    nxt_mod = mod_ff;
    case (mod_ff)
      gstm_pkg::GS_START: begin
        if (poll_tick && ack_seen_ff) begin
          nxt_mod = gstm_pkg::GS_RUN;
        end else if (poll_tick && miss_ff == 2'(`GS_MISS_MAX - 1)) begin
          nxt_mod = gstm_pkg::GS_FAULT;
        end
      end
      gstm_pkg::GS_RUN: begin
        if (poll_tick && !ack_seen_ff && miss_ff == 2'(`GS_MISS_MAX - 1)) begin
          nxt_mod = gstm_pkg::GS_FAULT;
        end
      end
      gstm_pkg::GS_FAULT: nxt_mod = gstm_pkg::GS_FAULT;
      default: nxt_mod = gstm_pkg::GS_START;
    endcase
    if (dev_rst) begin
      nxt_mod = gstm_pkg::GS_START;
    end
  end

  wire enter_run = (mod_ff != gstm_pkg::GS_RUN) && (nxt_mod == gstm_pkg::GS_RUN);
  wire enter_flt = (mod_ff != gstm_pkg::GS_FAULT) && (nxt_mod == gstm_pkg::GS_FAULT);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mod_ff <= gstm_pkg::GS_START;
      fault_ff <= 1'b0;
      fault_tx_ff <= 1'b0;
      value_ff <= 16'h0000;
      pwr_d_ff <= 1'b0;
      mod_en_ff <= 1'b1;
    end else begin
      mod_ff <= nxt_mod;
      fault_ff <= enter_flt ? 1'b1 : (enter_run ? 1'b0 : fault_ff);
      fault_tx_ff <= enter_flt || enter_run;
      value_ff <= nxt_value;
      pwr_d_ff <= bus_pwr_in;
      mod_en_ff <= (nxt_mod != gstm_pkg::GS_FAULT);
    end
  end

  // Polling period and missed-answer count
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      poll_cnt_ff <= 16'h0000;
      poll_ff <= 1'b0;
      miss_ff <= 2'h0;
      ack_seen_ff <= 1'b0;
    end else begin
      poll_cnt_ff <= (poll_tick || dev_rst) ? 16'h0000 : poll_cnt_ff + 16'h0001;
      poll_ff <= poll_tick && (mod_ff != gstm_pkg::GS_FAULT);
      if (dev_rst) begin
        miss_ff <= 2'h0;
        ack_seen_ff <= 1'b0;
      end else if (poll_tick) begin
        miss_ff <= ack_seen_ff ? 2'h0 : miss_ff + 2'h1;
        ack_seen_ff <= sns_ack_in;
      end else if (sns_ack_in) begin
        ack_seen_ff <= 1'b1;
      end
    end
  end

  // Seconds base for warm-up and uptime; power loss restarts both
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sec_cnt_ff <= 25'h0000000;
      warm_sec_ff <= 9'h000;
      up_sec_ff <= 17'h00000;
      warm_ff <= 1'b0;
      cal_ff <= 1'b0;
    end else begin
      sec_cnt_ff <= (sec_tick || !bus_pwr_in) ? 25'h0000000 : sec_cnt_ff + 25'h0000001;
      if (!bus_pwr_in || dev_rst) begin
        warm_sec_ff <= 9'h000;
        warm_ff <= 1'b0;
      end else if (sec_tick && !warm_ff) begin
        warm_sec_ff <= warm_sec_ff + 9'h001;
        warm_ff <= (warm_sec_ff == 9'(`GS_WARM_SEC - 1));
      end
      if (!bus_pwr_in) begin
        up_sec_ff <= 17'h00000;
      end else if (sec_tick && up_sec_ff != 17'(CAL_SEC)) begin
        up_sec_ff <= up_sec_ff + 17'h00001;
      end
      cal_ff <= bus_pwr_in && running && (up_sec_ff == 17'(CAL_SEC));
    end
  end

  // Register writes
  wire [2:0] page = addr_in[7:5];
  wire [2:0] idx = addr_in[4:2];
  wire idx_ok = (idx < 3'(NCH));
  wire wr_ctrl = wr_in && (addr_in == `GS_ADDR_CTRL);
  wire wr_alt = wr_in && (addr_in == `GS_ADDR_ALT);
  wire wr_irqs = wr_in && (addr_in == `GS_ADDR_IRQ_ST);
  wire wr_msk = wr_in && (addr_in == `GS_ADDR_IRQ_MSK);
  wire [2:0] n_co2 = (ctrl_ff[2:0] > 3'h4) ? 3'h4 : ctrl_ff[2:0];
  wire [1:0] n_hum = (ctrl_ff[5:4] > 2'h2) ? 2'h2 : ctrl_ff[5:4];
  localparam logic [15:0] RST_LIM [NCH] = '{`GS_LIM0_RST, `GS_LIM1_RST, `GS_LIM2_RST,
                                            `GS_LIM3_RST, `GS_LIM4_RST, `GS_LIM5_RST};

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_ff <= `GS_CTRL_RST;
      alt_ff <= `GS_ALT_RST;
      irq_msk_ff <= 3'h0;
      for (int i = 0; i < NCH; i++) begin
        cfg_lim_ff[i] <= RST_LIM[i];
        hyst_ff[i] <= (i < 4) ? `GS_HYST_CO2_RST : `GS_HYST_HUM_RST;
      end
    end else begin
      if (wr_ctrl) ctrl_ff <= wdata_in;
      if (wr_alt) alt_ff <= wdata_in;
      if (wr_msk) irq_msk_ff <= wdata_in[2:0];
      for (int i = 0; i < NCH; i++) begin
        if (wr_in && idx_ok && idx == 3'(i) && page == `GS_PAGE_LIM) cfg_lim_ff[i] <= wdata_in;
        if (wr_in && idx_ok && idx == 3'(i) && page == `GS_PAGE_HYST) hyst_ff[i] <= wdata_in;
      end
    end
  end

  // Threshold channels: 0..3 follow CO2, 4..5 follow humidity
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    wire is_co2 = (g < 4);
    wire act = is_co2 ? (3'(g) < n_co2) : (2'(g - 4) < n_hum);
    gstm_chan u_ch (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .load_in(dev_rst),
      .act_in(act),
      .dir_in(ctrl_ff[8 + g]),
      .cfg_lim_in(cfg_lim_ff[g]),
      .hyst_in(hyst_ff[g]),
      .ext_stb_in(ext_stb_in && ext_ch_in == 3'(g)),
      .ext_val_in(ext_val_in),
      .teach_stb_in(teach_stb_in && teach_bit_in && teach_ch_in == 3'(g)),
      .meas_in(is_co2 ? value_ff : hum_in),
      .eval_in(is_co2 ? co2_eval : hum_vld_in),
      .lim_out(lim_q[g]),
      .state_out(thr_q[g])
    );
  end

  // Sticky events; a new event beats a same-cycle clear
  wire [2:0] ev = {warm_ff && !warm_done_out, |(thr_q ^ thr_out), enter_flt || enter_run};
  wire [2:0] nxt_irq_st = (irq_st_ff & ~(wr_irqs ? wdata_in[2:0] : 3'h0)) | ev;

  // Read mux, data valid the cycle after the strobe
  wire [15:0] stat = {6'h00, thr_q, running, cal_ff, warm_ff, fault_ff};
  wire [15:0] rd_mux = (addr_in == `GS_ADDR_CTRL) ? ctrl_ff :
                       (addr_in == `GS_ADDR_ALT) ? alt_ff :
                       (addr_in == `GS_ADDR_STAT) ? stat :
                       (addr_in == `GS_ADDR_IRQ_ST) ? {13'h0000, irq_st_ff} :
                       (addr_in == `GS_ADDR_IRQ_MSK) ? {13'h0000, irq_msk_ff} :
                       (addr_in == `GS_ADDR_VALUE) ? value_ff :
                       (idx_ok && page == `GS_PAGE_LIM) ? lim_q[idx] :
                       (idx_ok && page == `GS_PAGE_HYST) ? hyst_ff[idx] : 16'h0000;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_st_ff <= 3'h0;
      irq_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      thr_out <= 6'h00;
      warm_done_out <= 1'b0;
    end else begin
      irq_st_ff <= nxt_irq_st;
      irq_ff <= |(nxt_irq_st & irq_msk_ff);
      rdata_ff <= rd_in ? rd_mux : 16'h0000;
      thr_out <= thr_q;
      warm_done_out <= warm_ff;
    end
  end

  assign rdata_out = rdata_ff;
  assign irq_out = irq_ff;
  assign co2_val_out = value_ff;
  assign fault_out = fault_ff;
  assign fault_tx_out = fault_tx_ff;
  assign poll_out = poll_ff;
  assign mod_en_out = mod_en_ff;
  assign cal_en_out = cal_ff;
endmodule // gstm_top
`default_nettype wire

// >>> include/gstm_params.svh
// Constants of the gas sensor threshold monitor
`ifndef GSTM_PARAMS_SVH
`define GSTM_PARAMS_SVH
`define GS_CLK_HZ 25000000
`define GS_WARMUP_MIN 5
`define GS_WARM_SEC (`GS_WARMUP_MIN * 60)
`define GS_CAL_HOURS 24
`define GS_CAL_SEC (`GS_CAL_HOURS * 3600)
`define GS_POLL_US 1000
`define GS_POLL_CYC ((`GS_POLL_US * (`GS_CLK_HZ / 1000000)))
`define GS_MISS_MAX 3
`define GS_SPAN_MAX 16'h07D0
`define GS_P0_RECIP 1656
`define GS_P0_SHIFT 24
`define GS_ALT_STEP 100
`define GS_NCH 6
`define GS_ADDR_CTRL 8'h00
`define GS_ADDR_ALT 8'h04
`define GS_ADDR_STAT 8'h08
`define GS_ADDR_IRQ_ST 8'h0C
`define GS_ADDR_IRQ_MSK 8'h10
`define GS_ADDR_VALUE 8'h14
`define GS_ADDR_LOAD 8'h18
`define GS_PAGE_LIM 3'h1
`define GS_PAGE_HYST 3'h2
`define GS_CTRL_RST 16'h0024
`define GS_ALT_RST 16'h0000
`define GS_LIM0_RST 16'h0190
`define GS_LIM1_RST 16'h0320
`define GS_LIM2_RST 16'h04B0
`define GS_LIM3_RST 16'h0640
`define GS_LIM4_RST 16'h0046
`define GS_LIM5_RST 16'h001E
`define GS_HYST_CO2_RST 16'h0032
`define GS_HYST_HUM_RST 16'h0005
`define GS_IRQ_FAULT 0
`define GS_IRQ_THR 1
`define GS_IRQ_WARM 2
`endif

// >>> include/gstm_pkg.sv
// Types of the gas sensor threshold monitor
package gstm_pkg;
  typedef enum logic [1:0] {
    GS_START,
    GS_RUN,
    GS_FAULT
  } gstm_mod_t;
endpackage

// >>> testbench/gstm_props.sv
// Checker of the gas sensor monitor top ports
`timescale 1ns/1ps
`default_nettype none
`include "gstm_params.svh"
module gstm_props #(
  parameter int unsigned SEC_CYC = 10,
  parameter int unsigned CAL_SEC = 20,
  parameter int unsigned POLL_CYC = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Inputs watched
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic bus_pwr_in,
  input wire logic sns_ack_in,
  // Outputs watched
  input wire logic poll_out,
  input wire logic mod_en_out,
  input wire logic cal_en_out,
  input wire logic warm_done_out,
  input wire logic [15:0] co2_val_out,
  input wire logic fault_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [31:0] up_ff;
  logic [15:0] gap_ff;
  wire logic ld_wr = wr_in && addr_in == `GS_ADDR_LOAD && wdata_in[0];
  // Uptime since power came back, and cycles since the last sensor answer
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_ff <= '0;
      gap_ff <= '0;
    end else begin
      up_ff <= bus_pwr_in ? up_ff + 32'h1 : '0;
      gap_ff <= sns_ack_in ? '0 : gap_ff + {15'h0, gap_ff != 16'hFFFF};
    end
  end
  a_fault_zero: assert property (fault_out && $past(fault_out) |-> co2_val_out == 16'h0000)
    else $error("value not zero while faulty");
  // The flag stays ON through a restart until the module answers, so only its rise implies a disabled module
  a_fault_off: assert property ($rose(fault_out) |-> !mod_en_out)
    else $error("module enabled while faulty");
  a_fault_kept: assert property (!mod_en_out && bus_pwr_in && $past(bus_pwr_in) && $past(bus_pwr_in, 2)
    && $past(bus_pwr_in, 3) && !ld_wr && !$past(ld_wr) |=> !mod_en_out) else $error("module left fault alone");
  a_span_max: assert property (co2_val_out <= `GS_SPAN_MAX)
    else $error("value above span");
  a_no_poll: assert property (!mod_en_out && !$past(mod_en_out) |-> !poll_out)
    else $error("poll while disabled");
  a_miss_count: assert property ($rose(fault_out) |-> gap_ff >= 3 * POLL_CYC - 2)
    else $error("fault before three silent periods");
  a_cal_uptime: assert property ($rose(cal_en_out) |-> up_ff >= CAL_SEC * SEC_CYC - 2)
    else $error("calibration too early");
  a_warm_uptime: assert property ($rose(warm_done_out) |-> up_ff >= 300 * SEC_CYC - 2)
    else $error("warm-up too short");
  // Warm-up done trails the internal flag by one register
  a_power_low: assert property (!bus_pwr_in && !$past(bus_pwr_in) && !$past(bus_pwr_in, 2)
    |-> !cal_en_out && !warm_done_out)
    else $error("power loss kept timers");
  c_fault: cover property ($rose(fault_out));
  c_warm: cover property ($rose(warm_done_out));
  c_cal: cover property ($rose(cal_en_out));
endmodule // gstm_props
bind gstm_top gstm_props #(.SEC_CYC(SEC_CYC), .CAL_SEC(CAL_SEC), .POLL_CYC(POLL_CYC)) u_gstm_props (
  .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .bus_pwr_in(bus_pwr_in), .sns_ack_in(sns_ack_in), .poll_out(poll_out), .mod_en_out(mod_en_out),
  .cal_en_out(cal_en_out), .warm_done_out(warm_done_out), .co2_val_out(co2_val_out), .fault_out(fault_out)
);
`default_nettype wire

// >>> testbench/gstm_sns_model.sv
// Model of the integrated sensor module answering polls
`timescale 1ns/1ps
`default_nettype none
module gstm_sns_model (
  // Clock and poll
  input wire logic clk_in,
  input wire logic poll_in,
  // Commands of the bench
  input wire logic mute_in,
  input wire logic slow_in,
  input wire logic [15:0] raw_in,
  input wire logic [15:0] hum_val_in,
  // Answer
  output logic ack_out,
  output logic [15:0] raw_out,
  output logic [15:0] hum_out
);
  logic [2:0] dly_ff = 3'h0;
  // A muted module never answers, which is how a broken link looks
  always @(posedge clk_in) begin
    if (poll_in && !mute_in) begin
      dly_ff <= slow_in ? 3'h5 : 3'h1;
    end else if (dly_ff != 3'h0) begin
      dly_ff <= dly_ff - 3'h1;
    end
  end
  assign ack_out = dly_ff == 3'h1;
  // Data lines carry junk outside the answer cycle
  assign raw_out = ack_out ? raw_in : ~raw_in;
  assign hum_out = ack_out ? hum_val_in : ~hum_val_in;
endmodule // gstm_sns_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench of the gas sensor monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'h0, nrst_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0, bus_pwr_in = 1'h1;
  logic ext_stb_in = 1'h0, teach_stb_in = 1'h0, teach_bit_in = 1'h0, mute = 1'h0, slow = 1'h0, irq_a;
  logic [7:0] addr_in = '0;
  logic [15:0] wdata_in = '0, ext_val_in = '0, raw = '0, hum = '0, rd_d;
  logic [2:0] ext_ch_in = '0, teach_ch_in = '0;
  wire logic [15:0] rdata_out, co2_val_out, co2_raw_in, hum_in;
  wire logic [5:0] thr_out;
  wire logic poll_out, mod_en_out, cal_en_out, warm_done_out, fault_out, fault_tx_out, irq_out, sns_ack_in;
  int err_total = 0, comparisons = 0, cyc = 0, i, n;
  logic [15:0] lim_def [6] = '{16'h0190, 16'h0320, 16'h04B0, 16'h0640, 16'h0046, 16'h001E};
  // Altitude, raw, humidity, expected value, expected threshold states
  logic [15:0] tab [4][5] = '{'{16'h041A, 16'h03E8, 16'h0050, 16'h0459, 16'h0033},
    '{16'h041A, 16'h0FA0, 16'h0050, 16'h07D0, 16'h003F}, '{16'h0000, 16'h030C, 16'h0020, 16'h030C, 16'h0023},
    '{16'h0000, 16'h02E4, 16'h0018, 16'h02E4, 16'h0001}};
  gstm_top #(.SEC_CYC(10), .CAL_SEC(20), .POLL_CYC(8)) u_gstm_top (.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .bus_pwr_in(bus_pwr_in), .co2_raw_in(co2_raw_in), .co2_vld_in(sns_ack_in), .sns_ack_in(sns_ack_in),
    .hum_in(hum_in), .hum_vld_in(sns_ack_in), .poll_out(poll_out), .mod_en_out(mod_en_out),
    .cal_en_out(cal_en_out), .warm_done_out(warm_done_out), .ext_stb_in(ext_stb_in), .ext_ch_in(ext_ch_in),
    .ext_val_in(ext_val_in), .teach_stb_in(teach_stb_in), .teach_ch_in(teach_ch_in),
    .teach_bit_in(teach_bit_in), .co2_val_out(co2_val_out), .fault_out(fault_out),
    .fault_tx_out(fault_tx_out), .thr_out(thr_out), .irq_out(irq_out));
  gstm_sns_model u_gstm_sns_model (.clk_in(clk_in), .poll_in(poll_out), .mute_in(mute), .slow_in(slow),
    .raw_in(raw), .hum_val_in(hum), .ack_out(sns_ack_in), .raw_out(co2_raw_in), .hum_out(hum_in));
  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) if (nrst_in) cyc <= cyc + 1;
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] e, input string nm);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 rd_d = rdata_out;
    cmp(nm, e, rd_d);
  endtask
  task automatic final_report;
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #600000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'h1;
    chk(8'h00, 16'h0024, "ctrl");
    for (i = 0; i < 6; i++) begin
      chk(8'h20 + 8'(4 * i), lim_def[i], "limit");
      chk(8'h40 + 8'(4 * i), i < 4 ? 16'h0032 : 16'h0005, "hyst");
    end
    chk(8'h7C, 16'h0000, "unmapped");
    repeat (40) @(posedge clk_in);
    chk(8'h08, 16'h0008, "status run");
    for (n = 0; n < 4000 && warm_done_out !== 1'h1; n++) @(posedge clk_in);
    cmp("warm time", 16'h0001, 16'(cyc >= 2998 && cyc <= 3004));
    chk(8'h08, 16'h000E, "status warm");
    for (i = 0; i < 4; i++) begin
      wr(8'h04, tab[i][0]);
      raw <= tab[i][1];
      hum <= tab[i][2];
      repeat (24) @(posedge clk_in);
      cmp("value", tab[i][3], co2_val_out);
      cmp("thr", tab[i][4], 16'(thr_out));
    end
    @(posedge clk_in);
    ext_ch_in <= 3'h2;
    ext_val_in <= 16'h02BC;
    ext_stb_in <= 1'h1;
    @(posedge clk_in);
    ext_stb_in <= 1'h0;
    chk(8'h28, 16'h02BC, "ext limit");
    repeat (24) @(posedge clk_in);
    cmp("thr ext", 16'h0005, 16'(thr_out));
    for (i = 0; i < 2; i++) begin
      @(posedge clk_in);
      teach_ch_in <= 3'h3;
      teach_bit_in <= i[0];
      teach_stb_in <= 1'h1;
      @(posedge clk_in);
      teach_stb_in <= 1'h0;
      chk(8'h2C, i ? 16'h02E4 : 16'h0640, "teach");
    end
    wr(8'h00, 16'h0011);
    repeat (24) @(posedge clk_in);
    cmp("thr count", 16'h0001, 16'(thr_out));
    wr(8'h00, 16'h0111);
    repeat (24) @(posedge clk_in);
    cmp("thr dir", 16'h0000, 16'(thr_out));
    wr(8'h2C, 16'h0514);
    wr(8'h4C, 16'h0064);
    chk(8'h2C, 16'h02E4, "cfg held");
    chk(8'h4C, 16'h0064, "hyst wr");
    wr(8'h18, 16'h0001);
    chk(8'h28, 16'h04B0, "reload");
    chk(8'h2C, 16'h0514, "reload");
    mute <= 1'h1;
    for (n = 0; n < 100 && fault_out !== 1'h1; n++) @(posedge clk_in);
    cmp("fault sent", 16'h0001, 16'(fault_tx_out));
    mute <= 1'h0;
    repeat (100) @(posedge clk_in);
    cmp("fault", 16'h0001, 16'(fault_out));
    cmp("mod off", 16'h0000, 16'(mod_en_out));
    cmp("value off", 16'h0000, co2_val_out);
    chk(8'h0C, 16'h0007, "irq status");
    wr(8'h10, 16'h0000);
    repeat (2) @(posedge clk_in);
    irq_a = irq_out;
    wr(8'h10, 16'h0007);
    repeat (2) @(posedge clk_in);
    cmp("irq mask", 16'h0001, 16'(irq_a ^ irq_out));
    wr(8'h0C, 16'h0007);
    repeat (2) @(posedge clk_in);
    cmp("irq clear", 16'h0000, 16'(irq_out));
    chk(8'h0C, 16'h0000, "irq status");
    bus_pwr_in <= 1'h0;
    slow <= 1'h1;
    repeat (5) @(posedge clk_in);
    bus_pwr_in <= 1'h1;
    for (n = 0; n < 60 && fault_out !== 1'h0; n++) @(posedge clk_in);
    cmp("clear sent", 16'h0001, 16'(fault_tx_out));
    repeat (20) @(posedge clk_in);
    cmp("fault cleared", 16'h0000, 16'(fault_out));
    chk(8'h08, 16'h0008, "status restart");
    final_report;
  end
endmodule // testbench
`default_nettype wire
